/* File: inc/xlate_pkg.sv */
// Constants for the segment and page address translation block
// What this block does
// [R01] Every access goes through segment translation; no switch turns it off.
// [R02] Linear address is segment descriptor base plus logical offset.
// [R03] Paging off: linear address goes unchanged onto the physical bus.
// [R04] Paging on: walk page directory then page table, 4 KByte pages.
// [R05] Page not present: abort access and raise a page fault.
// [R06] After reset the first instruction fetch is at FFFF_FFF0.
// [R07] Reset loads the data segment register base with zero.
// [R08] Base zero, 4 GByte limit never gives an out-of-limit fault.
// [R09] Offset beyond segment limit: general protection fault, no access.
// [R10] Code segments are read-only; writes to them fault.
// [R11] Descriptor gives size, rights, privilege, type and base; checks use them.
// [R12] Selector indexes the descriptor inside a descriptor table.
// [R13] Privilege levels 0 and 3 supported; overlapping segments allowed.
// [R14] Selector bits 15:3 index, bit 2 table select, bits 1:0 privilege.
// [R15] Descriptor address is table base plus index times eight.
// [R16] All checks finish before any physical bus cycle is issued.
package xlate_pkg;
	// Reset values
	localparam logic [31:0] RESET_FETCH_ADDR = 32'hFFFF_FFF0;
	localparam logic [31:0] DS_RESET_BASE    = 32'h0000_0000;
	// Data segment after reset: 4 GByte limit, level 3, writable data
	localparam logic [31:0] DS_RESET_ATTR    = 32'h017F_FFFF;

	// Selector layout
	localparam int SEL_IDX_HI = 15;
	localparam int SEL_IDX_LO = 3;
	localparam int SEL_TBL    = 2;
	localparam int SEL_RPL_HI = 1;
	localparam int SEL_RPL_LO = 0;

	// Descriptor: word 0 holds the base, word 1 the attributes
	localparam logic [2:0]  DESC_SHIFT = 3'h3;
	localparam logic [31:0] WORD_STEP  = 32'h0000_0004;
	localparam int ATTR_LIM_HI = 19;
	localparam int ATTR_LIM_LO = 0;
	localparam int ATTR_GRAN   = 20;
	localparam int ATTR_DPL_HI = 22;
	localparam int ATTR_DPL_LO = 21;
	localparam int ATTR_CODE   = 23;
	localparam int ATTR_WRITE  = 24;

	// Two-level paging with 4 KByte pages
	localparam logic [11:0] PAGE_FILL  = 12'hFFF;
	localparam int PAGE_SHIFT  = 12;
	localparam int DIR_HI      = 31;
	localparam int DIR_LO      = 22;
	localparam int TBL_HI      = 21;
	localparam int TBL_LO      = 12;
	localparam int ENT_PRESENT = 0;

	typedef enum logic [2:0]
	{
		ST_BOOT  = 3'b000,
		ST_IDLE  = 3'b001,
		ST_DESC0 = 3'b010,
		ST_DESC1 = 3'b011,
		ST_CHECK = 3'b100,
		ST_PDE   = 3'b101,
		ST_PTE   = 3'b110
	} xlate_state_t;
endpackage

/* File: logic/addr_translate.sv */
// Segment translation, protection checks and optional paging
`timescale 1ns/1ps
`default_nettype none

module addr_translate
(
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST,
	// Logical access from the execution core
	input  wire logic        REQ_VALID,
	input  wire logic [15:0] REQ_SEL,
	input  wire logic [31:0] REQ_OFFSET,
	input  wire logic        REQ_WRITE,
	input  wire logic        REQ_USE_DS,
	input  wire logic        REQ_LOAD_DS,
	input  wire logic [1:0]  CUR_PRIV,
	output logic             REQ_READY,
	// Completion
	output logic             DONE,
	output logic             GP_FAULT,
	output logic             PAGE_FAULT,
	output logic [31:0]      FAULT_ADDR,
	output logic [31:0]      DS_BASE,
	// Translation setup
	input  wire logic        PAGING_ON,
	input  wire logic [31:0] GDT_BASE,
	input  wire logic [31:0] LDT_BASE,
	input  wire logic [31:0] PDIR_BASE,
	// Table reads
	output logic             TBL_RD_REQ,
	output logic [31:0]      TBL_RD_ADDR,
	input  wire logic        TBL_RD_VALID,
	input  wire logic [31:0] TBL_RD_DATA,
	// Physical address bus
	output logic             PHYS_VALID,
	output logic [31:0]      PHYS_ADDR,
	output logic             PHYS_WRITE
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	xlate_pkg::xlate_state_t state_r, state_nxt;

	logic        ready_r,   ready_nxt;
	logic        done_r,    done_nxt;
	logic        gp_r,      gp_nxt;
	logic        pf_r,      pf_nxt;
	logic [31:0] faddr_r,   faddr_nxt;
	logic        rd_req_r,  rd_req_nxt;
	logic [31:0] rd_addr_r, rd_addr_nxt;
	logic        pv_r,      pv_nxt;
	logic [31:0] pa_r,      pa_nxt;
	logic        pw_r,      pw_nxt;

	logic [15:0] sel_r,     sel_nxt;
	logic [31:0] off_r,     off_nxt;
	logic        wr_r,      wr_nxt;
	logic        load_r,    load_nxt;
	logic [1:0]  cpl_r,     cpl_nxt;
	logic [31:0] base_r,    base_nxt;
	logic [31:0] attr_r,    attr_nxt;
	logic [31:0] ds_base_r, ds_base_nxt;
	logic [31:0] ds_attr_r, ds_attr_nxt;

	// ------------------------------------------------------------
	// Check terms, valid in the check state; lin_held is valid in the page walk states
	// ------------------------------------------------------------
	logic [31:0] eff_limit;
	logic [31:0] lin_addr;
	logic [1:0]  dpl;
	logic [1:0]  requested_privilege_field;
	logic [1:0]  need_priv;
	logic        over_limit;
	logic        priv_bad;
	logic        write_bad;
	logic        seg_fault;
	logic [31:0] lin_held;

	always_comb
	begin
		// Page granular limits fill the low 12 bits so 4 GBytes is all ones
		if (attr_r[xlate_pkg::ATTR_GRAN])
			eff_limit = {attr_r[xlate_pkg::ATTR_LIM_HI:xlate_pkg::ATTR_LIM_LO],
				xlate_pkg::PAGE_FILL}; // R08
		else
			eff_limit = {12'h000,
				attr_r[xlate_pkg::ATTR_LIM_HI:xlate_pkg::ATTR_LIM_LO]};
		lin_addr   = base_r + off_r; // R02
		dpl        = attr_r[xlate_pkg::ATTR_DPL_HI:xlate_pkg::ATTR_DPL_LO];
		requested_privilege_field        = sel_r[xlate_pkg::SEL_RPL_HI:xlate_pkg::SEL_RPL_LO];
		need_priv  = (cpl_r > requested_privilege_field) ? cpl_r : requested_privilege_field;
		over_limit = off_r > eff_limit; // R09
		// Numerically larger is less privileged; equal levels may overlap
		priv_bad   = dpl < need_priv; // R13
		write_bad  = wr_r & (attr_r[xlate_pkg::ATTR_CODE] |
			~attr_r[xlate_pkg::ATTR_WRITE]); // R10
		seg_fault  = over_limit | priv_bad | write_bad; // R11
		lin_held   = faddr_r;
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt   = state_r;
		ready_nxt   = ready_r;
		done_nxt    = 1'b0;
		gp_nxt      = 1'b0;
		pf_nxt      = 1'b0;
		faddr_nxt   = faddr_r;
		rd_req_nxt  = 1'b0;
		rd_addr_nxt = rd_addr_r;
		pv_nxt      = 1'b0;
		pa_nxt      = pa_r;
		pw_nxt      = pw_r;
		sel_nxt     = sel_r;
		off_nxt     = off_r;
		wr_nxt      = wr_r;
		load_nxt    = load_r;
		cpl_nxt     = cpl_r;
		base_nxt    = base_r;
		attr_nxt    = attr_r;
		ds_base_nxt = ds_base_r;
		ds_attr_nxt = ds_attr_r;

		case (state_r)
			xlate_pkg::ST_BOOT:
			begin
				// One instruction fetch cycle straight out of reset
				pv_nxt    = 1'b1;
				pa_nxt    = xlate_pkg::RESET_FETCH_ADDR; // R06
				pw_nxt    = 1'b0;
				ready_nxt = 1'b1;
				state_nxt = xlate_pkg::ST_IDLE;
			end

			xlate_pkg::ST_IDLE:
			begin
				if (REQ_VALID)
				begin
					sel_nxt   = REQ_SEL;
					off_nxt   = REQ_OFFSET;
					wr_nxt    = REQ_WRITE;
					load_nxt  = REQ_LOAD_DS;
					cpl_nxt   = CUR_PRIV;
					ready_nxt = 1'b0;
					if (REQ_USE_DS && !REQ_LOAD_DS)
					begin
						// Cached data segment needs no table read
						base_nxt  = ds_base_r;
						attr_nxt  = ds_attr_r;
						sel_nxt   = {14'h0000, CUR_PRIV};
						state_nxt = xlate_pkg::ST_CHECK; // R01
					end
					else if (REQ_SEL[xlate_pkg::SEL_IDX_HI:xlate_pkg::SEL_TBL]
						== 14'h0000)
					begin
						// Null selector cannot reach memory
						gp_nxt    = 1'b1;
						done_nxt  = 1'b1;
						faddr_nxt = REQ_OFFSET;
						ready_nxt = 1'b1;
					end
					else
					begin
						rd_req_nxt  = 1'b1;
						rd_addr_nxt = (REQ_SEL[xlate_pkg::SEL_TBL] ?
							LDT_BASE : GDT_BASE) + // R14
							{16'h0000,
							REQ_SEL[xlate_pkg::SEL_IDX_HI:xlate_pkg::SEL_IDX_LO],
							3'b000}; // R15
						state_nxt   = xlate_pkg::ST_DESC0; // R12
					end
				end
			end

			xlate_pkg::ST_DESC0:
			begin
				if (TBL_RD_VALID)
				begin
					base_nxt    = TBL_RD_DATA; // R11
					rd_req_nxt  = 1'b1;
					rd_addr_nxt = rd_addr_r + xlate_pkg::WORD_STEP;
					state_nxt   = xlate_pkg::ST_DESC1;
				end
			end

			xlate_pkg::ST_DESC1:
			begin
				if (TBL_RD_VALID)
				begin
					attr_nxt = TBL_RD_DATA; // R11
					if (load_r)
					begin
						ds_base_nxt = base_r;
						ds_attr_nxt = TBL_RD_DATA;
						done_nxt    = 1'b1;
						ready_nxt   = 1'b1;
						state_nxt   = xlate_pkg::ST_IDLE;
					end
					else
						state_nxt = xlate_pkg::ST_CHECK;
				end
			end

			xlate_pkg::ST_CHECK:
			begin
				faddr_nxt = lin_addr;
				if (seg_fault)
				begin
					// Fault leaves the physical bus untouched
					gp_nxt    = 1'b1; // R16
					done_nxt  = 1'b1;
					ready_nxt = 1'b1;
					state_nxt = xlate_pkg::ST_IDLE;
				end
				else if (PAGING_ON)
				begin
					rd_req_nxt  = 1'b1;
					rd_addr_nxt = {PDIR_BASE[31:xlate_pkg::PAGE_SHIFT],
						lin_addr[xlate_pkg::DIR_HI:xlate_pkg::DIR_LO],
						2'b00}; // R04
					state_nxt   = xlate_pkg::ST_PDE;
				end
				else
				begin
					pv_nxt    = 1'b1;
					pa_nxt    = lin_addr; // R03
					pw_nxt    = wr_r;
					done_nxt  = 1'b1;
					ready_nxt = 1'b1;
					state_nxt = xlate_pkg::ST_IDLE;
				end
			end

			xlate_pkg::ST_PDE:
			begin
				if (TBL_RD_VALID)
				begin
					if (!TBL_RD_DATA[xlate_pkg::ENT_PRESENT])
					begin
						pf_nxt    = 1'b1; // R05
						done_nxt  = 1'b1;
						ready_nxt = 1'b1;
						state_nxt = xlate_pkg::ST_IDLE;
					end
					else
					begin
						rd_req_nxt  = 1'b1;
						rd_addr_nxt = {TBL_RD_DATA[31:xlate_pkg::PAGE_SHIFT],
							lin_held[xlate_pkg::TBL_HI:xlate_pkg::TBL_LO],
							2'b00}; // R04
						state_nxt   = xlate_pkg::ST_PTE;
					end
				end
			end

			xlate_pkg::ST_PTE:
			begin
				if (TBL_RD_VALID)
				begin
					done_nxt  = 1'b1;
					ready_nxt = 1'b1;
					state_nxt = xlate_pkg::ST_IDLE;
					if (!TBL_RD_DATA[xlate_pkg::ENT_PRESENT])
						pf_nxt = 1'b1; // R05
					else
					begin
						pv_nxt = 1'b1;
						pa_nxt = {TBL_RD_DATA[31:xlate_pkg::PAGE_SHIFT],
							lin_held[xlate_pkg::PAGE_SHIFT-1:0]}; // R04
						pw_nxt = wr_r;
					end
				end
			end

			default:
			begin
				ready_nxt = 1'b1;
				state_nxt = xlate_pkg::ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			state_r   <= xlate_pkg::ST_BOOT;
			ready_r   <= 1'b0;
			done_r    <= 1'b0;
			gp_r      <= 1'b0;
			pf_r      <= 1'b0;
			faddr_r   <= 32'h0000_0000;
			rd_req_r  <= 1'b0;
			rd_addr_r <= 32'h0000_0000;
			pv_r      <= 1'b0;
			pa_r      <= 32'h0000_0000;
			pw_r      <= 1'b0;
			sel_r     <= 16'h0000;
			off_r     <= 32'h0000_0000;
			wr_r      <= 1'b0;
			load_r    <= 1'b0;
			cpl_r     <= 2'h0;
			base_r    <= 32'h0000_0000;
			attr_r    <= 32'h0000_0000;
			ds_base_r <= xlate_pkg::DS_RESET_BASE; // R07
			ds_attr_r <= xlate_pkg::DS_RESET_ATTR; // R08
		end
		else
		begin
			state_r   <= state_nxt;
			ready_r   <= ready_nxt;
			done_r    <= done_nxt;
			gp_r      <= gp_nxt;
			pf_r      <= pf_nxt;
			faddr_r   <= faddr_nxt;
			rd_req_r  <= rd_req_nxt;
			rd_addr_r <= rd_addr_nxt;
			pv_r      <= pv_nxt;
			pa_r      <= pa_nxt;
			pw_r      <= pw_nxt;
			sel_r     <= sel_nxt;
			off_r     <= off_nxt;
			wr_r      <= wr_nxt;
			load_r    <= load_nxt;
			cpl_r     <= cpl_nxt;
			base_r    <= base_nxt;
			attr_r    <= attr_nxt;
			ds_base_r <= ds_base_nxt;
			ds_attr_r <= ds_attr_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign REQ_READY   = ready_r;
	assign DONE        = done_r;
	assign GP_FAULT    = gp_r;
	assign PAGE_FAULT  = pf_r;
	assign FAULT_ADDR  = faddr_r;
	assign DS_BASE     = ds_base_r;
	assign TBL_RD_REQ  = rd_req_r;
	assign TBL_RD_ADDR = rd_addr_r;
	assign PHYS_VALID  = pv_r;
	assign PHYS_ADDR   = pa_r;
	assign PHYS_WRITE  = pw_r;

endmodule

`default_nettype wire

/* File: sim/addr_translate_props.sv */
// Concurrent checks for the address translation block
`timescale 1ns/1ps
`default_nettype none

module addr_translate_props
(
	// Clock and reset
	input wire logic        MCLK,
	input wire logic        RST,
	// Core side
	input wire logic        REQ_VALID,
	input wire logic [15:0] REQ_SEL,
	input wire logic [31:0] REQ_OFFSET,
	input wire logic        REQ_USE_DS,
	input wire logic        REQ_LOAD_DS,
	input wire logic        REQ_READY,
	input wire logic        DONE,
	input wire logic        GP_FAULT,
	input wire logic        PAGE_FAULT,
	input wire logic [31:0] DS_BASE,
	// Tables and bus
	input wire logic        PAGING_ON,
	input wire logic [31:0] GDT_BASE,
	input wire logic [31:0] LDT_BASE,
	input wire logic        TBL_RD_REQ,
	input wire logic [31:0] TBL_RD_ADDR,
	input wire logic        PHYS_VALID,
	input wire logic [31:0] PHYS_ADDR
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);

	sequence s_take;
		REQ_READY && REQ_VALID;
	endsequence
	sequence s_ds_rd;
		s_take ##0 REQ_USE_DS && !REQ_LOAD_DS ##1 !PAGING_ON;
	endsequence

	property p_boot;
		$fell(RST) |=> PHYS_VALID
			&& PHYS_ADDR == xlate_pkg::RESET_FETCH_ADDR;
	endproperty
	property p_ds_rst;
		$fell(RST) |-> DS_BASE == xlate_pkg::DS_RESET_BASE;
	endproperty
	property p_ds_path;
		s_ds_rd |-> !REQ_READY ##1 DONE && (GP_FAULT || PHYS_VALID
			&& PHYS_ADDR == $past(DS_BASE, 2) + $past(REQ_OFFSET, 2));
	endproperty
	property p_desc;
		s_take ##0 !REQ_USE_DS && REQ_SEL[15:2] != 14'h0 |=> TBL_RD_REQ
			&& !REQ_READY && TBL_RD_ADDR == {16'h0, $past(REQ_SEL[15:3]), 3'h0}
			+ ($past(REQ_SEL[2]) ? $past(LDT_BASE) : $past(GDT_BASE));
	endproperty
	property p_null;
		s_take ##0 !REQ_USE_DS && !REQ_LOAD_DS && REQ_SEL[15:2] == 14'h0
			|=> DONE && GP_FAULT;
	endproperty
	property p_quiet;
		GP_FAULT || PAGE_FAULT |-> DONE && !PHYS_VALID;
	endproperty
	property p_rd_pulse;
		TBL_RD_REQ |=> !TBL_RD_REQ;
	endproperty
	property p_bus_pulse;
		PHYS_VALID |=> !PHYS_VALID;
	endproperty

	a_boot: assert property (p_boot) else $error("bad boot fetch");
	a_ds_rst: assert property (p_ds_rst) else $error("bad ds base");
	a_ds_path: assert property (p_ds_path) else $error("bad ds path");
	a_desc: assert property (p_desc) else $error("bad desc read");
	a_null: assert property (p_null) else $error("null not refused");
	a_quiet: assert property (p_quiet) else $error("fault with bus");
	a_rd_pulse: assert property (p_rd_pulse) else $error("long read");
	a_bus_pulse: assert property (p_bus_pulse) else $error("long bus");
endmodule

bind addr_translate addr_translate_props addr_translate_props_inst (.*);

`default_nettype wire

/* File: sim/segment_page_address_translation_tb_top.sv */
// Self-checking bench for the address translation block
`timescale 1ns/1ps
`default_nettype none

module segment_page_address_translation_tb_top;
	typedef struct packed
	{
		logic [15:0] sel;
		logic [31:0] off;
		logic [2:0]  f;
		logic [1:0]  priv;
		logic [1:0]  e;
		logic [31:0] pa;
	} row_t;

	logic        MCLK = 1'h0;
	logic        RST = 1'h1;
	logic        REQ_VALID = 1'h0;
	logic [15:0] REQ_SEL = 16'h0;
	logic [31:0] REQ_OFFSET = 32'h0;
	logic        REQ_WRITE = 1'h0;
	logic        REQ_USE_DS = 1'h0;
	logic        REQ_LOAD_DS = 1'h0;
	logic [1:0]  CUR_PRIV = 2'h0;
	logic        PAGING_ON = 1'h0;
	logic [31:0] GDT_BASE = 32'h1000;
	logic [31:0] LDT_BASE = 32'h2000;
	logic [31:0] PDIR_BASE = 32'h3000;
	logic [3:0]  LAT = 4'h1;
	logic        REQ_READY, DONE, GP_FAULT, PAGE_FAULT, PHYS_VALID;
	logic        TBL_RD_REQ, TBL_RD_VALID, PHYS_WRITE;
	logic [31:0] FAULT_ADDR, DS_BASE, TBL_RD_ADDR, TBL_RD_DATA, PHYS_ADDR;
	int          miscompares = 0;
	int          tests_run = 0;
	row_t        rows [11];

	addr_translate addr_translate_inst (.*);
	tmem tmem_inst (.*);

	initial forever #2 MCLK = ~MCLK;

	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// --------
	// One access: f is {write, use ds, paging}, e is {gp, page fault}
	// --------
	task automatic run(row_t r, logic ld);
		int n;
		@(posedge MCLK);
		{REQ_VALID, REQ_SEL, REQ_OFFSET, REQ_LOAD_DS} <= {1'h1, r.sel, r.off, ld};
		{REQ_WRITE, REQ_USE_DS, PAGING_ON, CUR_PRIV} <= {r.f, r.priv};
		@(posedge MCLK);
		REQ_VALID <= 1'h0;
		#1;
		for (n = 0; DONE !== 1'h1 && n < 200; n++)
			@(posedge MCLK) #1;
		chk("done", 32'h1, {31'h0, DONE});
		chk("fault", {30'h0, r.e}, {30'h0, GP_FAULT, PAGE_FAULT});
		chk("bus", {31'h0, r.e == 2'h0 && !ld}, {31'h0, PHYS_VALID});
		if (r.e == 2'h0 && !ld)
		begin
			chk("addr", r.pa, PHYS_ADDR);
			chk("write", {31'h0, r.f[2]}, {31'h0, PHYS_WRITE});
		end
		// Faulting rows carry the linear address that the fault reports
		if (r.e != 2'h0)
			chk("fault_addr", r.pa, FAULT_ADDR);
	endtask

	task automatic boot_check;
		@(posedge MCLK) #1;
		chk("boot_valid", 32'h1, {31'h0, PHYS_VALID});
		chk("boot_addr", xlate_pkg::RESET_FETCH_ADDR, PHYS_ADDR);
		chk("ds_rst", 32'h0, DS_BASE);
	endtask

	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		tmem_inst.mem[32'h1008] = 32'h10000;
		tmem_inst.mem[32'h100C] = 32'h0100_0FFF;
		tmem_inst.mem[32'h1010] = 32'h20000;
		tmem_inst.mem[32'h1014] = 32'h0080_0FFF;
		tmem_inst.mem[32'h2008] = 32'h0;
		tmem_inst.mem[32'h200C] = 32'h017F_FFFF;
		tmem_inst.mem[32'h3000] = 32'h4001;
		tmem_inst.mem[32'h4000] = 32'h70001;
		tmem_inst.mem[32'h4040] = 32'h90001;
		tmem_inst.mem[32'h4044] = 32'h90000;
		rows = '{
			'{16'h8, 32'h10, 3'h0, 2'h0, 2'h0, 32'h10010},
			'{16'h8, 32'hFFF, 3'h4, 2'h0, 2'h0, 32'h10FFF},
			'{16'h8, 32'h1000, 3'h0, 2'h0, 2'h2, 32'h11000},
			'{16'h10, 32'h4, 3'h4, 2'h0, 2'h2, 32'h20004},
			'{16'hB, 32'h0, 3'h0, 2'h0, 2'h2, 32'h10000},
			'{16'hF, 32'hFFFF_FFFF, 3'h4, 2'h3, 2'h0, 32'hFFFF_FFFF},
			'{16'h0, 32'h0, 3'h0, 2'h0, 2'h2, 32'h0},
			'{16'h0, 32'h1234_5678, 3'h6, 2'h3, 2'h0, 32'h1234_5678},
			'{16'h8, 32'h10, 3'h1, 2'h0, 2'h0, 32'h90010},
			'{16'hF, 32'h11010, 3'h1, 2'h3, 2'h1, 32'h11010},
			'{16'h0, 32'h20, 3'h3, 2'h0, 2'h0, 32'h70020}
		};
		repeat (8) @(posedge MCLK);
		RST <= 1'h0;
		boot_check();
		foreach (rows[i])
		begin
			run(rows[i], 1'h0);
			$display("Row %0d done", i);
		end
		run(rows[0], 1'h1);
		chk("ds_load", 32'h10000, DS_BASE);
		run('{16'h0, 32'h20, 3'h6, 2'h0, 2'h0, 32'h10020}, 1'h0);
		run('{16'h0, 32'h1000, 3'h2, 2'h0, 2'h2, 32'h11000}, 1'h0);
		LAT <= 4'h9;
		run(rows[8], 1'h0);
		run(rows[9], 1'h0);
		@(posedge MCLK);
		RST <= 1'h1;
		repeat (3) @(posedge MCLK);
		RST <= 1'h0;
		boot_check();
		$display("Hand tests done");
		tally_and_finish();
	end

	// Watchdog: the whole run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge MCLK);
		miscompares++;
		tally_and_finish();
	end
endmodule

`default_nettype wire

/* File: sim/tmem.sv */
// Table memory model that answers descriptor and page entry reads
`timescale 1ns/1ps
`default_nettype none

module tmem
(
	// Clock, reset and answer delay in cycles (one at least)
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic [3:0]  LAT,
	// Read port
	input  wire logic        TBL_RD_REQ,
	input  wire logic [31:0] TBL_RD_ADDR,
	output logic             TBL_RD_VALID,
	output logic [31:0]      TBL_RD_DATA
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] addr_r;
	logic [3:0]  cnt_r;
	logic        busy_r;

	// Data toggles outside the valid cycle, so a stale word is never reused
	always_ff @(posedge MCLK)
	begin
		TBL_RD_VALID <= 1'h0;
		TBL_RD_DATA <= ~TBL_RD_DATA;
		if (RST)
		begin
			busy_r <= 1'h0;
			TBL_RD_DATA <= 32'hA5A5_5A5A;
		end
		else if (TBL_RD_REQ)
		begin
			busy_r <= 1'h1;
			addr_r <= TBL_RD_ADDR;
			cnt_r <= LAT;
		end
		else if (busy_r && cnt_r < 4'h2)
		begin
			busy_r <= 1'h0;
			TBL_RD_VALID <= 1'h1;
			TBL_RD_DATA <= mem.exists(addr_r) ? mem[addr_r] : ~addr_r;
		end
		else if (busy_r)
			cnt_r <= cnt_r - 4'h1;
	end
endmodule

`default_nettype wire
